// [design/ppcr_pkg.sv]
// Constants for the port configuration and data register block.
// Assumes one 200 MHz clock and a byte-wide microcontroller register port.
// Contract
// - On ports A and B, mode bit 0 gives general I/O, 1 gives latched address.
// - Only ports A and B have the mode-select register; C and D never address.
// - Bit n of every configuration register acts only on pin n of its port.
// - Mode, direction and drive registers all come up as zero.
// - Direction bit 1 makes the pin an output, 0 leaves it an input.
// - On ports A, B and C, direction bit OR logic-array enable drives the pin.
// - Without an active logic-array enable, the direction bit alone rules.
// - Port D direction holds only its three low bits.
// - Drive bit 1 on an open-drain pin gives open drain, 0 push-pull.
// - Drive bit 1 on a slew pin gives fast slew, 0 slow slew.
// - A/B: bits 7-4 open drain, 3-0 slew; C all open drain; D 2-0 slew.
// - Reading input data returns the live pin levels whatever the direction.
// - Output data register holds writes and drives every enabled pin not set to address output, save an open-drain pin it sets to 1.
// - Reading output data returns the last written value, not the pins.
// - Macrocell locations read back the current macrocell flip-flop values.
// - A write to a macrocell location loads every flip-flop whose mask is 0.
// - Mask bit 1 blocks loading its macrocell by a write; reset value 0.
// - Registers are reached by plain read and write cycles at fixed offsets.
// - Port C pins can be released to the programming port while it is on.
// - Enable status of ports A, B and C reads 1 for each enabled pin, including an open-drain pin tri-stated by a 1.
package ppcr_pkg;

  localparam int PORT_W = 8;
  localparam int PORTD_W = 3;

  localparam logic [7:0] OFS_IN_A    = 8'h00;
  localparam logic [7:0] OFS_IN_B    = 8'h01;
  localparam logic [7:0] OFS_MODE_A  = 8'h02;
  localparam logic [7:0] OFS_MODE_B  = 8'h03;
  localparam logic [7:0] OFS_DOUT_A  = 8'h04;
  localparam logic [7:0] OFS_DOUT_B  = 8'h05;
  localparam logic [7:0] OFS_DIR_A   = 8'h06;
  localparam logic [7:0] OFS_DIR_B   = 8'h07;
  localparam logic [7:0] OFS_DRV_A   = 8'h08;
  localparam logic [7:0] OFS_DRV_B   = 8'h09;
  localparam logic [7:0] OFS_OEN_A   = 8'h0c;
  localparam logic [7:0] OFS_OEN_B   = 8'h0d;
  localparam logic [7:0] OFS_IN_C    = 8'h10;
  localparam logic [7:0] OFS_IN_D    = 8'h11;
  localparam logic [7:0] OFS_DOUT_C  = 8'h14;
  localparam logic [7:0] OFS_DOUT_D  = 8'h15;
  localparam logic [7:0] OFS_DIR_C   = 8'h16;
  localparam logic [7:0] OFS_DIR_D   = 8'h17;
  localparam logic [7:0] OFS_DRV_C   = 8'h18;
  localparam logic [7:0] OFS_DRV_D   = 8'h19;
  localparam logic [7:0] OFS_OEN_C   = 8'h1c;
  localparam logic [7:0] OFS_MC_AB   = 8'h20;
  localparam logic [7:0] OFS_MC_BC   = 8'h21;
  localparam logic [7:0] OFS_MASK_AB = 8'h22;
  localparam logic [7:0] OFS_MASK_BC = 8'h23;

  localparam logic [7:0] RST_CFG  = 8'h00;
  localparam logic [7:0] RST_DOUT = 8'h00;
  localparam logic [7:0] RST_MC   = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RD_NONE  = 8'h00;

  localparam logic [7:0] OD_MASK_AB   = 8'hf0;
  localparam logic [7:0] SLEW_MASK_AB = 8'h0f;
  localparam logic [7:0] OD_MASK_C    = 8'hff;
  localparam logic [7:0] SLEW_MASK_C  = 8'h00;
  localparam logic [2:0] OD_MASK_D    = 3'h0;
  localparam logic [2:0] SLEW_MASK_D  = 3'h7;

endpackage

// [design/ppcr_pin_drv.sv]
// Per-port pin driver: direction merge, open drain and slew selection.
// Assumes pin outputs, enables and slew controls feed pad cells directly.
`timescale 1ns/1ps
module ppcr_pin_drv #(
  parameter int          W         = 8,
  parameter logic [W-1:0] OD_MASK   = '0,
  parameter logic [W-1:0] SLEW_MASK = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] oe_term,
  input  wire logic [W-1:0] drive_sel,
  input  wire logic [W-1:0] data,
  input  wire logic         release_pins,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] slew_fast,
  output logic      [W-1:0] drv_en
);

  wire [W-1:0] next_en   = (dir | oe_term) & {W{~release_pins}};
  wire [W-1:0] od_on     = drive_sel & OD_MASK;
  wire [W-1:0] next_oe   = next_en & ~(od_on & data);
  wire [W-1:0] next_out  = data & ~od_on;
  wire [W-1:0] next_slew = drive_sel & SLEW_MASK;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out   <= '0;
      pin_oe    <= '0;
      slew_fast <= '0;
      drv_en    <= '0;
    end else begin
      pin_out   <= next_out;
      pin_oe    <= next_oe;
      slew_fast <= next_slew;
      drv_en    <= next_en;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_merge;
    ##1 drv_en == (($past(dir) | $past(oe_term)) & {W{~$past(release_pins)}});
  endproperty
  a_merge: assert property (p_merge) else $error("direction merge wrong");

  property p_od_low;
    ##1 ((pin_out & ($past(drive_sel) & OD_MASK)) == '0);
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drove high");

  property p_off_float;
    (pin_oe & ~drv_en) == '0;
  endproperty
  a_off_float: assert property (p_off_float) else $error("idle pin driven");

  property p_slew;
    ##1 slew_fast == ($past(drive_sel) & SLEW_MASK);
  endproperty
  a_slew: assert property (p_slew) else $error("slew select wrong");

endmodule

// [design/ppcr_port_regs.sv]
// Port configuration and data registers for four ports and macrocell access.
// Assumes single-cycle read and write strobes from the microcontroller bus,
// qualified by the I/O register region select, synchronous to clk.
`timescale 1ns/1ps
module ppcr_port_regs (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        io_sel,
  input  wire logic                        bus_rd,
  input  wire logic                        bus_wr,
  input  wire logic [7:0]                  bus_addr,
  input  wire logic [7:0]                  bus_wdata,
  output logic      [7:0]                  bus_rdata,
  input  wire logic [ppcr_pkg::PORT_W-1:0] pa_in,
  input  wire logic [ppcr_pkg::PORT_W-1:0] pb_in,
  input  wire logic [ppcr_pkg::PORT_W-1:0] pc_in,
  input  wire logic [ppcr_pkg::PORTD_W-1:0] pd_in,
  input  wire logic [ppcr_pkg::PORT_W-1:0] pa_oe_term,
  input  wire logic [ppcr_pkg::PORT_W-1:0] pb_oe_term,
  input  wire logic [ppcr_pkg::PORT_W-1:0] pc_oe_term,
  input  wire logic [ppcr_pkg::PORT_W-1:0] addr_out_a,
  input  wire logic [ppcr_pkg::PORT_W-1:0] addr_out_b,
  input  wire logic                        jtag_on,
  input  wire logic [7:0]                  mc_ab_next,
  input  wire logic                        mc_ab_load,
  input  wire logic [7:0]                  mc_bc_next,
  input  wire logic                        mc_bc_load,
  output logic      [7:0]                  mc_ab,
  output logic      [7:0]                  mc_bc,
  output logic      [ppcr_pkg::PORT_W-1:0] pa_out,
  output logic      [ppcr_pkg::PORT_W-1:0] pa_oe,
  output logic      [ppcr_pkg::PORT_W-1:0] pa_slew,
  output logic      [ppcr_pkg::PORT_W-1:0] pb_out,
  output logic      [ppcr_pkg::PORT_W-1:0] pb_oe,
  output logic      [ppcr_pkg::PORT_W-1:0] pb_slew,
  output logic      [ppcr_pkg::PORT_W-1:0] pc_out,
  output logic      [ppcr_pkg::PORT_W-1:0] pc_oe,
  output logic      [ppcr_pkg::PORT_W-1:0] pc_slew,
  output logic      [ppcr_pkg::PORTD_W-1:0] pd_out,
  output logic      [ppcr_pkg::PORTD_W-1:0] pd_oe,
  output logic      [ppcr_pkg::PORTD_W-1:0] pd_slew
);
  import ppcr_pkg::*;

  logic [7:0] mode_a, mode_b, dir_a, dir_b, dir_c;
  logic [2:0] dir_d, drv_d, dout_d;
  logic [7:0] drv_a, drv_b, drv_c, dout_a, dout_b, dout_c;
  logic [7:0] mask_ab, mask_bc;
  logic [7:0] en_a, en_b, en_c;

  wire wr_hit = io_sel & bus_wr;
  wire rd_hit = io_sel & bus_rd;

  wire we_mode_a  = wr_hit & (bus_addr == OFS_MODE_A);
  wire we_mode_b  = wr_hit & (bus_addr == OFS_MODE_B);
  wire we_dir_a   = wr_hit & (bus_addr == OFS_DIR_A);
  wire we_dir_b   = wr_hit & (bus_addr == OFS_DIR_B);
  wire we_dir_c   = wr_hit & (bus_addr == OFS_DIR_C);
  wire we_dir_d   = wr_hit & (bus_addr == OFS_DIR_D);
  wire we_drv_a   = wr_hit & (bus_addr == OFS_DRV_A);
  wire we_drv_b   = wr_hit & (bus_addr == OFS_DRV_B);
  wire we_drv_c   = wr_hit & (bus_addr == OFS_DRV_C);
  wire we_drv_d   = wr_hit & (bus_addr == OFS_DRV_D);
  wire we_dout_a  = wr_hit & (bus_addr == OFS_DOUT_A);
  wire we_dout_b  = wr_hit & (bus_addr == OFS_DOUT_B);
  wire we_dout_c  = wr_hit & (bus_addr == OFS_DOUT_C);
  wire we_dout_d  = wr_hit & (bus_addr == OFS_DOUT_D);
  wire we_mc_ab   = wr_hit & (bus_addr == OFS_MC_AB);
  wire we_mc_bc   = wr_hit & (bus_addr == OFS_MC_BC);
  wire we_mask_ab = wr_hit & (bus_addr == OFS_MASK_AB);
  wire we_mask_bc = wr_hit & (bus_addr == OFS_MASK_BC);

  // Logic-array loads land first; an unmasked bus write then overrides.
  wire [7:0] mc_ab_base = mc_ab_load ? mc_ab_next : mc_ab;
  wire [7:0] mc_bc_base = mc_bc_load ? mc_bc_next : mc_bc;
  wire [7:0] next_mc_ab = we_mc_ab ?
       ((bus_wdata & ~mask_ab) | (mc_ab_base & mask_ab)) : mc_ab_base;
  wire [7:0] next_mc_bc = we_mc_bc ?
       ((bus_wdata & ~mask_bc) | (mc_bc_base & mask_bc)) : mc_bc_base;

  // Address output only replaces the data on pins whose mode bit is set.
  wire [7:0] data_a = (mode_a & addr_out_a) | (~mode_a & dout_a);
  wire [7:0] data_b = (mode_b & addr_out_b) | (~mode_b & dout_b);

  wire [7:0] rd_value =
    (bus_addr == OFS_IN_A)    ? pa_in :
    (bus_addr == OFS_IN_B)    ? pb_in :
    (bus_addr == OFS_IN_C)    ? pc_in :
    (bus_addr == OFS_IN_D)    ? {5'h00, pd_in} :
    (bus_addr == OFS_MODE_A)  ? mode_a :
    (bus_addr == OFS_MODE_B)  ? mode_b :
    (bus_addr == OFS_DOUT_A)  ? dout_a :
    (bus_addr == OFS_DOUT_B)  ? dout_b :
    (bus_addr == OFS_DOUT_C)  ? dout_c :
    (bus_addr == OFS_DOUT_D)  ? {5'h00, dout_d} :
    (bus_addr == OFS_DIR_A)   ? dir_a :
    (bus_addr == OFS_DIR_B)   ? dir_b :
    (bus_addr == OFS_DIR_C)   ? dir_c :
    (bus_addr == OFS_DIR_D)   ? {5'h00, dir_d} :
    (bus_addr == OFS_DRV_A)   ? drv_a :
    (bus_addr == OFS_DRV_B)   ? drv_b :
    (bus_addr == OFS_DRV_C)   ? drv_c :
    (bus_addr == OFS_DRV_D)   ? {5'h00, drv_d} :
    (bus_addr == OFS_OEN_A)   ? en_a :
    (bus_addr == OFS_OEN_B)   ? en_b :
    (bus_addr == OFS_OEN_C)   ? en_c :
    (bus_addr == OFS_MC_AB)   ? mc_ab :
    (bus_addr == OFS_MC_BC)   ? mc_bc :
    (bus_addr == OFS_MASK_AB) ? mask_ab :
    (bus_addr == OFS_MASK_BC) ? mask_bc : RD_NONE;

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_a <= RST_CFG;
      mode_b <= RST_CFG;
      dir_a  <= RST_CFG;
      dir_b  <= RST_CFG;
      dir_c  <= RST_CFG;
      dir_d  <= RST_CFG[2:0];
      drv_a  <= RST_CFG;
      drv_b  <= RST_CFG;
      drv_c  <= RST_CFG;
      drv_d  <= RST_CFG[2:0];
    end else begin
      if (we_mode_a) mode_a <= bus_wdata;
      if (we_mode_b) mode_b <= bus_wdata;
      if (we_dir_a)  dir_a  <= bus_wdata;
      if (we_dir_b)  dir_b  <= bus_wdata;
      if (we_dir_c)  dir_c  <= bus_wdata;
      if (we_dir_d)  dir_d  <= bus_wdata[2:0];
      if (we_drv_a)  drv_a  <= bus_wdata;
      if (we_drv_b)  drv_b  <= bus_wdata;
      if (we_drv_c)  drv_c  <= bus_wdata;
      if (we_drv_d)  drv_d  <= bus_wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dout_a    <= RST_DOUT;
      dout_b    <= RST_DOUT;
      dout_c    <= RST_DOUT;
      dout_d    <= RST_DOUT[2:0];
      mc_ab     <= RST_MC;
      mc_bc     <= RST_MC;
      mask_ab   <= RST_MASK;
      mask_bc   <= RST_MASK;
      bus_rdata <= RD_NONE;
    end else begin
      if (we_dout_a)  dout_a  <= bus_wdata;
      if (we_dout_b)  dout_b  <= bus_wdata;
      if (we_dout_c)  dout_c  <= bus_wdata;
      if (we_dout_d)  dout_d  <= bus_wdata[2:0];
      if (we_mask_ab) mask_ab <= bus_wdata;
      if (we_mask_bc) mask_bc <= bus_wdata;
      mc_ab <= next_mc_ab;
      mc_bc <= next_mc_bc;
      if (rd_hit) bus_rdata <= rd_value;
    end
  end

  ppcr_pin_drv #(.W(8), .OD_MASK(OD_MASK_AB), .SLEW_MASK(SLEW_MASK_AB)) u_a (
    .clk          (clk),
    .rst          (rst),
    .dir          (dir_a),
    .oe_term      (pa_oe_term),
    .drive_sel    (drv_a),
    .data         (data_a),
    .release_pins (1'b0),
    .pin_out      (pa_out),
    .pin_oe       (pa_oe),
    .slew_fast    (pa_slew),
    .drv_en       (en_a)
  );

  ppcr_pin_drv #(.W(8), .OD_MASK(OD_MASK_AB), .SLEW_MASK(SLEW_MASK_AB)) u_b (
    .clk          (clk),
    .rst          (rst),
    .dir          (dir_b),
    .oe_term      (pb_oe_term),
    .drive_sel    (drv_b),
    .data         (data_b),
    .release_pins (1'b0),
    .pin_out      (pb_out),
    .pin_oe       (pb_oe),
    .slew_fast    (pb_slew),
    .drv_en       (en_b)
  );

  // Programming only happens outside normal operation, so releasing the
  // whole port while it is enabled costs the application nothing.
  ppcr_pin_drv #(.W(8), .OD_MASK(OD_MASK_C), .SLEW_MASK(SLEW_MASK_C)) u_c (
    .clk          (clk),
    .rst          (rst),
    .dir          (dir_c),
    .oe_term      (pc_oe_term),
    .drive_sel    (drv_c),
    .data         (dout_c),
    .release_pins (jtag_on),
    .pin_out      (pc_out),
    .pin_oe       (pc_oe),
    .slew_fast    (pc_slew),
    .drv_en       (en_c)
  );

  // Port D has no logic-array enable, so its direction bits rule alone.
  ppcr_pin_drv #(.W(3), .OD_MASK(OD_MASK_D), .SLEW_MASK(SLEW_MASK_D)) u_d (
    .clk          (clk),
    .rst          (rst),
    .dir          (dir_d),
    .oe_term      (3'h0),
    .drive_sel    (drv_d),
    .data         (dout_d),
    .release_pins (1'b0),
    .pin_out      (pd_out),
    .pin_oe       (pd_oe),
    .slew_fast    (pd_slew),
    .drv_en       ()
  );

  default clocking cb @(posedge clk); endclocking

  property p_reset_cfg;
    $past(rst) |-> (mode_a == RST_CFG && dir_b == RST_CFG &&
                    drv_c == RST_CFG && dir_d == 3'h0 && pa_oe == '0);
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset");

  property p_dout_back;
    disable iff (rst)
    (wr_hit && bus_addr == OFS_DOUT_B) ##1 !wr_hit ##1
    (rd_hit && bus_addr == OFS_DOUT_B && !wr_hit)
    |=> bus_rdata == $past(bus_wdata, 3);
  endproperty
  a_dout_back: assert property (p_dout_back) else $error("readback");

  property p_pin_read;
    disable iff (rst)
    (rd_hit && bus_addr == OFS_IN_C) |=> bus_rdata == $past(pc_in);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read");

  property p_mask_load;
    disable iff (rst)
    (we_mc_ab && !mc_ab_load) |=>
      mc_ab == (($past(bus_wdata) & ~$past(mask_ab)) |
                ($past(mc_ab) & $past(mask_ab)));
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask load");

  property p_no_mode_c;
    disable iff (rst)
    (rd_hit && (bus_addr == 8'h12 || bus_addr == 8'h13)) |=>
      bus_rdata == RD_NONE;
  endproperty
  a_no_mode_c: assert property (p_no_mode_c) else $error("mode C/D");

  property p_dir_d;
    disable iff (rst)
    (rd_hit && bus_addr == OFS_DIR_D) |=> bus_rdata[7:3] == 5'h00;
  endproperty
  a_dir_d: assert property (p_dir_d) else $error("dir D upper");

  property p_addr_out;
    disable iff (rst)
    (mode_a[0] && dir_a[0] && !drv_a[4]) |=>
      pa_oe[0] && pa_out[0] == $past(addr_out_a[0]);
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("address out");

  // Masked bits must keep their old value even when a bus write hits them.
  property p_mask_block;
    disable iff (rst)
    (we_mc_bc && !mc_bc_load) |=>
      ((mc_bc ^ $past(mc_bc)) & $past(mask_bc)) == 8'h00;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("mask");

  property p_jtag_rel;
    disable iff (rst)
    jtag_on |=> pc_oe == 8'h00;
  endproperty
  a_jtag_rel: assert property (p_jtag_rel) else $error("release");

  // Port D has neither a logic-array enable nor open drain to mask it.
  property p_dir_d_pins;
    disable iff (rst)
    1'b1 |=> pd_oe == $past(dir_d);
  endproperty
  a_dir_d_pins: assert property (p_dir_d_pins) else $error("dir D");

  property p_in_d;
    disable iff (rst)
    (rd_hit && bus_addr == OFS_IN_D) |=> bus_rdata == {5'h00, $past(pd_in)};
  endproperty
  a_in_d: assert property (p_in_d) else $error("pin D read");

  c_addr_out: cover property (disable iff (rst) mode_b[3] && dir_b[3]);
  c_mc_load: cover property (disable iff (rst) mc_bc_load);
  c_masked: cover property (disable iff (rst) we_mc_bc && mask_bc != 8'h00);
  c_jtag: cover property (disable iff (rst) jtag_on && dir_c != 8'h00);

endmodule

// [sim/ppcr_mcu_model.sv]
// Microcontroller bus model: single read and write cycles to the block.
// Assumes the block takes a strobe on the rising edge of clk.
`timescale 1ns/1ps
module ppcr_mcu_model (
  input  wire logic       clk,
  output logic            io_sel,
  output logic            bus_rd,
  output logic            bus_wr,
  output logic      [7:0] bus_addr,
  output logic      [7:0] bus_wdata,
  input  wire logic [7:0] bus_rdata
);
  initial begin
    io_sel = 1'b0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
  end

  // Released lines show the inverse so no stale value looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_sel <= 1'b1;
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    io_sel <= 1'b0;
    bus_wr <= 1'b0;
    bus_addr <= ~a;
    bus_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    io_sel <= 1'b1;
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    io_sel <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~a;
    #1;
    d = bus_rdata;
  endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the port configuration and data registers.
// Assumes the bus model in ppcr_mcu_model and one 200 MHz clock.
`timescale 1ns/1ps
module tb_top;
  import ppcr_pkg::*;
  logic       clk, rst, io_sel, bus_rd, bus_wr, jtag_on;
  logic       mc_ab_load, mc_bc_load;
  logic [7:0] bus_addr, bus_wdata, bus_rdata, mc_ab_next, mc_bc_next;
  logic [7:0] pa_in, pb_in, pc_in, pa_oe_term, pb_oe_term, pc_oe_term;
  logic [7:0] addr_out_a, addr_out_b, mc_ab, mc_bc;
  logic [7:0] pa_out, pa_oe, pa_slew, pb_out, pb_oe, pb_slew;
  logic [7:0] pc_out, pc_oe, pc_slew;
  logic [2:0] pd_in, pd_out, pd_oe, pd_slew;
  int         miscompares, check_count, cycles;

  ppcr_mcu_model mcu (.clk(clk), .io_sel(io_sel), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata));

  ppcr_port_regs uut (.clk(clk), .rst(rst), .io_sel(io_sel),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .pa_in(pa_in),
    .pb_in(pb_in), .pc_in(pc_in), .pd_in(pd_in), .pa_oe_term(pa_oe_term),
    .pb_oe_term(pb_oe_term), .pc_oe_term(pc_oe_term),
    .addr_out_a(addr_out_a), .addr_out_b(addr_out_b), .jtag_on(jtag_on),
    .mc_ab_next(mc_ab_next), .mc_ab_load(mc_ab_load),
    .mc_bc_next(mc_bc_next), .mc_bc_load(mc_bc_load), .mc_ab(mc_ab),
    .mc_bc(mc_bc), .pa_out(pa_out), .pa_oe(pa_oe), .pa_slew(pa_slew),
    .pb_out(pb_out), .pb_oe(pb_oe), .pb_slew(pb_slew), .pc_out(pc_out),
    .pc_oe(pc_oe), .pc_slew(pc_slew), .pd_out(pd_out), .pd_oe(pd_oe),
    .pd_slew(pd_slew));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang costs one mismatch and ends the run at the same verdict.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] d;
    mcu.rd(a, d);
    chk(d, want);
  endtask

  // Pins are registered from registers that were written one edge earlier.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    logic [7:0] ofs [11] = '{OFS_MODE_A, OFS_MODE_B, OFS_DIR_A, OFS_DIR_B,
      OFS_DIR_C, OFS_DIR_D, OFS_DRV_A, OFS_DRV_B, OFS_DRV_C, OFS_DRV_D,
      OFS_MASK_BC};
    foreach (ofs[i]) rdchk(ofs[i], 8'h00);
    chk(pa_oe | pb_oe | pc_oe | {5'h00, pd_oe}, 8'h00);
  endtask

  task automatic t_dir();
    mcu.wr(OFS_DOUT_A, 8'ha5);
    mcu.wr(OFS_DIR_A, 8'h0f);
    settle();
    chk(pa_oe, 8'h0f);
    chk(pa_out, 8'ha5);
    rdchk(OFS_DOUT_A, 8'ha5);
    rdchk(OFS_IN_A, 8'h3c);
    rdchk(OFS_OEN_A, 8'h0f);
  endtask

  task automatic t_merge();
    mcu.wr(OFS_DOUT_B, 8'h3c);
    rdchk(OFS_DOUT_B, 8'h3c);
    @(posedge clk);
    pb_oe_term <= 8'h3c;
    mcu.wr(OFS_DIR_B, 8'h81);
    settle();
    chk(pb_oe, 8'hbd);
    rdchk(OFS_OEN_B, 8'hbd);
    pb_oe_term <= 8'h00;
    settle();
    chk(pb_oe, 8'h81);
  endtask

  task automatic t_drive();
    mcu.wr(OFS_DRV_A, 8'hff);
    mcu.wr(OFS_DIR_A, 8'hff);
    mcu.wr(OFS_DRV_B, 8'h81);
    settle();
    chk(pa_out, 8'h05);
    chk(pa_oe, 8'h5f);
    chk(pa_slew, 8'h0f);
    chk(pb_slew, 8'h01);
    chk(pb_oe, 8'h81);
    chk(pb_out, 8'h3c);
  endtask

  task automatic t_portc();
    mcu.wr(OFS_DOUT_C, 8'h0f);
    mcu.wr(OFS_DIR_C, 8'hff);
    mcu.wr(OFS_DRV_C, 8'hff);
    settle();
    chk(pc_out, 8'h00);
    chk(pc_oe, 8'hf0);
    chk(pc_slew, 8'h00);
    jtag_on <= 1'b1;
    settle();
    chk(pc_oe, 8'h00);
    jtag_on <= 1'b0;
    pc_in <= 8'h96;
    rdchk(OFS_IN_C, 8'h96);
  endtask

  task automatic t_portd();
    mcu.wr(OFS_DIR_D, 8'hff);
    rdchk(OFS_DIR_D, 8'h07);
    mcu.wr(OFS_DRV_D, 8'hff);
    mcu.wr(OFS_DOUT_D, 8'h05);
    settle();
    chk({5'h00, pd_slew}, 8'h07);
    chk({5'h00, pd_oe}, 8'h07);
    chk({5'h00, pd_out}, 8'h05);
    rdchk(OFS_IN_D, 8'h06);
  endtask

  task automatic t_mode();
    @(posedge clk);
    addr_out_a <= 8'hc3;
    mcu.wr(OFS_DRV_A, 8'h00);
    mcu.wr(OFS_MODE_A, 8'h0f);
    settle();
    chk(pa_out, 8'ha3);
    rdchk(OFS_MODE_A, 8'h0f);
    addr_out_b <= 8'h5a;
    mcu.wr(OFS_MODE_B, 8'hf8);
    mcu.wr(OFS_DIR_B, 8'hff);
    settle();
    chk(pb_out, 8'h5c);
    chk(pb_oe, 8'hff);
    mcu.wr(8'h12, 8'hff);
    rdchk(8'h12, RD_NONE);
    rdchk(8'h30, RD_NONE);
  endtask

  task automatic t_mc();
    mcu.wr(OFS_MASK_AB, 8'hf0);
    rdchk(OFS_MASK_AB, 8'hf0);
    mcu.wr(OFS_MC_AB, 8'h5a);
    #1;
    chk(mc_ab, 8'h0a);
    rdchk(OFS_MC_AB, 8'h0a);
    @(posedge clk);
    mc_bc_next <= 8'h66;
    mc_bc_load <= 1'b1;
    @(posedge clk);
    mc_bc_load <= 1'b0;
    rdchk(OFS_MC_BC, 8'h66);
    mcu.wr(OFS_MC_BC, 8'hc9);
    rdchk(OFS_MC_BC, 8'hc9);
    mcu.wr(OFS_MASK_BC, 8'h0f);
    mcu.wr(OFS_MC_BC, 8'h30);
    #1;
    chk(mc_bc, 8'h39);
  endtask

  initial begin
    rst = 1'b1;
    jtag_on = 1'b0;
    pa_in = 8'h3c;
    pb_in = 8'h00;
    pc_in = 8'h00;
    pd_in = 3'h6;
    {pa_oe_term, pb_oe_term, pc_oe_term} = '0;
    {addr_out_a, addr_out_b, mc_ab_next, mc_bc_next} = '0;
    {mc_ab_load, mc_bc_load} = 2'b00;
    {miscompares, check_count} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_dir();
    t_merge();
    t_drive();
    t_portc();
    t_portd();
    t_mode();
    t_mc();
    report_and_stop();
  end
endmodule
